/* File: dv/flash_led_pulse_count_control_test.sv */
`default_nettype none
`define CMP(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, s); end end
module flash_led_pulse_count_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	import flash_ctrl_pkg::*;
	logic       core_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       en_set_pin, flash_trigger_in, flash_inhibit_in;
	logic       sink_low, at_ovp, hot, short_ok;
	logic       boost_enable, test_current_en, latched_off, channel_disabled;
	logic [1:0] led_drive_mode, flash_ratio_sel;
	logic [3:0] current_step;
	int         mismatches = 0, samples_checked = 0, seed = 27965, k;
	logic [7:0] q[$];
	event       look;
	string      nm[6] = '{"drive", "step", "ratio", "boost", "latched", "chan_dis"};
	initial forever #50 core_clk = ~core_clk;
	host_pins host (
		.core_clk        (core_clk),
		.en_set_pin      (en_set_pin),
		.flash_trigger_in(flash_trigger_in),
		.flash_inhibit_in(flash_inhibit_in)
	);
	flash_led_pulse_count_control #(
		.LATCH_CYCLES(20), .OFF_CYCLES(40), .QUARTER_CYCLES(50)
	) dut (
		.core_clk             (core_clk),
		.sys_rst              (sys_rst),
		.en_set_pin           (en_set_pin),
		.flash_trigger_in     (flash_trigger_in),
		.flash_inhibit_in     (flash_inhibit_in),
		.led_sink_pin_low     (sink_low),
		.output_at_ovp        (at_ovp),
		.over_temp            (hot),
		.led_sink_pin_short_ok(short_ok),
		.boost_enable         (boost_enable),
		.test_current_en      (test_current_en),
		.led_drive_mode       (led_drive_mode),
		.current_step         (current_step),
		.flash_ratio_sel      (flash_ratio_sel),
		.latched_off          (latched_off),
		.channel_disabled     (channel_disabled)
	);
	function automatic logic [3:0] seen(input int s);
		case (s)
			0: return {2'b00, led_drive_mode};
			1: return current_step;
			2: return {2'b00, flash_ratio_sel};
			3: return {3'b000, boost_enable};
			4: return {3'b000, latched_off};
			default: return {3'b000, channel_disabled};
		endcase
	endfunction
	// note an expected value; the monitor compares it against the outputs
	task automatic chk(input int s, input logic [3:0] v);
		q.push_back({s[3:0], v});
		->look;
	endtask
	initial forever begin
		@(look);
		while (q.size() > 0) begin
			logic [7:0] e;
			e = q.pop_front();
			`CMP(nm[e[7:4]], e[3:0], seen(int'(e[7:4])))
		end
	end
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		final_report();
	end
	initial begin
		{sink_low, at_ovp, hot, short_ok} = 4'h1;
		repeat (20) @(negedge core_clk);
		sys_rst = 1'b0;
		chk(3, 4'h0);
		chk(0, 4'h0);
		host.burst(1, 110);
		chk(0, {2'b00, DRV_TORCH});
		chk(1, 4'h0);
		chk(3, 4'h1);
		chk(5, 4'h0);
		// short random comparator glitches must not latch the device off
		for (int i = 0; i < 30; i++) begin
			@(negedge core_clk);
			{sink_low, at_ovp, hot, short_ok} = 4'($random(seed));
		end
		{sink_low, at_ovp, hot, short_ok} = 4'h1;
		repeat (4) @(negedge core_clk);
		chk(4, 4'h0);
		chk(0, {2'b00, DRV_TORCH});
		k = 2 + ($unsigned($random(seed)) % 15);
		host.write(0, k);
		chk(1, 4'(k - 1));
		host.burst(5, 26);
		chk(1, 4'h4);
		host.burst(22, 26);
		chk(1, 4'h4);
		host.burst(3, 26);
		chk(1, 4'h2);
		host.write(2, 1);
		chk(0, {2'b00, DRV_OFF});
		host.write(2, 3);
		chk(0, {2'b00, DRV_TORCH});
		host.write(3, 3);
		host.pins(1'b1, 1'b0, 6);
		chk(0, {2'b00, DRV_FLASH});
		chk(2, 4'h2);
		chk(1, 4'h2);
		host.pins(1'b1, 1'b1, 6);
		chk(0, {2'b00, DRV_TORCH});
		chk(1, 4'h0);
		host.pins(1'b1, 1'b0, 6);
		chk(0, {2'b00, DRV_FLASH});
		host.write(0, 7);
		chk(1, 4'h6);
		host.pins(1'b0, 1'b0, 6);
		chk(0, {2'b00, DRV_OFF});
		host.write(1, 2);
		host.pins(1'b1, 1'b0, 10);
		chk(0, {2'b00, DRV_FLASH});
		repeat (55) @(negedge core_clk);
		chk(0, {2'b00, DRV_OFF});
		host.pins(1'b0, 1'b0, 6);
		chk(0, {2'b00, DRV_OFF});
		host.off(45);
		chk(3, 4'h0);
		short_ok = 1'b0;
		host.burst(1, 110);
		chk(5, 4'h1);
		host.burst(4, 26);
		chk(1, 4'h0);
		for (int f = 0; f < 2; f++) begin
			host.off(45);
			short_ok = 1'b1;
			host.burst(1, 110);
			host.burst(4, 26);
			chk(1, 4'h3);
			@(negedge core_clk);
			sink_low = (f == 0);
			at_ovp = (f == 0);
			hot = (f == 1);
			repeat (PROT_CYC + 20) @(negedge core_clk);
			chk(4, 4'h1);
			chk(3, 4'h0);
			sink_low = 1'b0;
			at_ovp = 1'b0;
			hot = 1'b0;
			host.off(45);
			chk(4, 4'h0);
		end
		repeat (2) @(negedge core_clk);
		final_report();
	end
endmodule
`default_nettype wire

/* File: dv/host_pins.sv */
`default_nettype none
module host_pins (
	input  wire logic core_clk,
	output logic      en_set_pin,
	output logic      flash_trigger_in,
	output logic      flash_inhibit_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		en_set_pin = 1'b0;
		flash_trigger_in = 1'b0;
		flash_inhibit_in = 1'b0;
	end
	// n rising edges, then pin held high so the count latches
	task automatic burst(input int n, input int hold);
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk) en_set_pin = 1'b0;
			@(negedge core_clk) en_set_pin = 1'b1;
		end
		repeat (hold) @(negedge core_clk);
	endtask
	// address burst then data burst, each followed by the latch pause
	task automatic write(input int a, input int d);
		burst(a + 17, 26);
		burst(d, 26);
	endtask
	// long low on the pin shuts the device down
	task automatic off(input int n);
		@(negedge core_clk) en_set_pin = 1'b0;
		repeat (n) @(negedge core_clk);
	endtask
	task automatic pins(input logic t, input logic i, input int w);
		@(negedge core_clk);
		flash_trigger_in = t;
		flash_inhibit_in = i;
		repeat (w) @(negedge core_clk);
	endtask
endmodule
`default_nettype wire

/* File: src/flash_ctrl_pkg.sv */
`default_nettype none
package flash_ctrl_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_LATCH_US    = 500;
	localparam int T_OFF_US      = 500;
	localparam int T_PROT_US     = 1400;
	localparam int T_QUARTER_MS  = 250;
	localparam int T_TEST_US     = 10;
	localparam int LATCH_CYC     = T_LATCH_US * 1000 / CLK_PERIOD_NS;
	localparam int OFF_CYC       = T_OFF_US * 1000 / CLK_PERIOD_NS;
	localparam int PROT_CYC      = T_PROT_US * 1000 / CLK_PERIOD_NS;
	localparam int QUARTER_CYC   = T_QUARTER_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TEST_CYC      = (T_TEST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// widths
	localparam int CNT_W  = 16;
	localparam int SAFE_W = 22;
	localparam int TEST_W = 8;
	// pulse counts
	localparam logic [4:0] EDGE_NONE     = 5'h00;
	localparam logic [4:0] EDGE_DATA_MAX = 5'h10;
	localparam logic [4:0] EDGE_ADDR_MIN = 5'h11;
	localparam logic [4:0] EDGE_ADDR_MAX = 5'h14;
	localparam logic [4:0] EDGE_SAT      = 5'h1F;
	// register addresses
	localparam logic [1:0] ADDR_TORCH  = 2'h0;
	localparam logic [1:0] ADDR_SAFETY = 2'h1;
	localparam logic [1:0] ADDR_ENABLE = 2'h2;
	localparam logic [1:0] ADDR_RATIO  = 2'h3;
	// stored value is data code minus one
	localparam logic [3:0] DEF_TORCH     = 4'h0;
	localparam logic [3:0] DEF_SAFETY    = 4'h4;
	localparam logic [3:0] DEF_ENABLE    = 4'h3;
	localparam logic [3:0] DEF_RATIO     = 4'h0;
	localparam logic [3:0] SAFE_OFF      = 4'h0;
	localparam logic [3:0] SAFE_MAXQ     = 4'h7;
	localparam logic [3:0] ENABLE_ON_MIN = 4'h2;
	localparam logic [3:0] RATIO_MAX     = 4'h3;
	// led drive modes
	localparam logic [1:0] DRV_OFF   = 2'h0;
	localparam logic [1:0] DRV_TORCH = 2'h1;
	localparam logic [1:0] DRV_FLASH = 2'h2;

	typedef enum logic [5:0] {
		ST_SHDN  = 6'h01,
		ST_TEST  = 6'h02,
		ST_READY = 6'h04,
		ST_FLASH = 6'h08,
		ST_DONE  = 6'h10,
		ST_FAULT = 6'h20
	} mode_t;

	typedef struct packed {
		logic              en_s1;
		logic              en_s2;
		logic              en_d;
		logic              trg_s1;
		logic              trg_s2;
		logic              trg_d;
		logic              inh_s1;
		logic              inh_s2;
		logic              low_s1;
		logic              low_s2;
		logic              ovp_s1;
		logic              ovp_s2;
		logic              hot_s1;
		logic              hot_s2;
		logic              shd_s1;
		logic              shd_s2;
		mode_t             state;
		logic              enabled;
		logic              chan_dis;
		logic [4:0]        edges;
		logic [CNT_W-1:0]  hi_cnt;
		logic [CNT_W-1:0]  lo_cnt;
		logic [CNT_W-1:0]  flt_cnt;
		logic [CNT_W-1:0]  hot_cnt;
		logic [TEST_W-1:0] test_cnt;
		logic [SAFE_W-1:0] safe_cnt;
		logic [3:0]        quarters;
		logic [1:0]        addr;
		logic [3:0][3:0]   reg_val;
		logic [3:0]        reg_set;
		logic [1:0]        drive;
		logic [3:0]        step;
		logic [1:0]        ratio;
	} ctrl_state_t;

	localparam ctrl_state_t RST_STATE = '{state: ST_SHDN, default: '0};
endpackage
`default_nettype wire

/* File: src/flash_led_pulse_count_control.sv */
`default_nettype none
module flash_led_pulse_count_control
	import flash_ctrl_pkg::*;
#(
	parameter int LATCH_CYCLES   = flash_ctrl_pkg::LATCH_CYC,
	parameter int OFF_CYCLES     = flash_ctrl_pkg::OFF_CYC,
	parameter int PROT_CYCLES    = flash_ctrl_pkg::PROT_CYC,
	parameter int QUARTER_CYCLES = flash_ctrl_pkg::QUARTER_CYC
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// host pins
	input  wire logic       en_set_pin,
	input  wire logic       flash_trigger_in,
	input  wire logic       flash_inhibit_in,
	// analog comparators
	input  wire logic       led_sink_pin_low,
	input  wire logic       output_at_ovp,
	input  wire logic       over_temp,
	input  wire logic       led_sink_pin_short_ok,
	// drive controls
	output logic            boost_enable,
	output logic            test_current_en,
	output logic [1:0]      led_drive_mode,
	output logic [3:0]      current_step,
	output logic [1:0]      flash_ratio_sel,
	// status
	output logic            latched_off,
	output logic            channel_disabled
);
	import flash_ctrl_pkg::*;

	localparam logic [CNT_W-1:0]  LAT_MAX  = CNT_W'(LATCH_CYCLES);
	localparam logic [CNT_W-1:0]  OFF_MAX  = CNT_W'(OFF_CYCLES);
	localparam logic [CNT_W-1:0]  PROT_MAX = CNT_W'(PROT_CYCLES);
	localparam logic [SAFE_W-1:0] QTR_LAST = SAFE_W'(QUARTER_CYCLES - 1);
	localparam logic [TEST_W-1:0] TST_LAST = TEST_W'(TEST_CYC - 1);

	ctrl_state_t q;
	ctrl_state_t n;

	logic       en_rise;
	logic       trg_rise;
	logic       latch_now;
	logic       shut_now;
	logic       fault_now;
	logic       safe_expire;
	logic [3:0] safety_idx;
	logic [3:0] safe_limit;

	assign en_rise     = q.en_s2 & ~q.en_d;
	assign trg_rise    = q.trg_s2 & ~q.trg_d;
	assign latch_now   = q.en_s2 && q.hi_cnt == LAT_MAX && q.edges != EDGE_NONE;
	assign shut_now    = !q.en_s2 && q.lo_cnt == OFF_MAX && q.enabled;
	assign fault_now   = q.state != ST_SHDN && (q.flt_cnt == PROT_MAX || q.hot_cnt == PROT_MAX);
	assign safety_idx  = q.reg_set[ADDR_SAFETY] ? q.reg_val[ADDR_SAFETY] : DEF_SAFETY;
	assign safe_limit  = (safety_idx > SAFE_MAXQ) ? SAFE_MAXQ : safety_idx;
	assign safe_expire = q.state == ST_FLASH && safe_limit != SAFE_OFF && q.quarters == safe_limit;

	always_comb begin
		logic [3:0] torch_idx;
		logic [3:0] enable_idx;
		logic [3:0] ratio_idx;
		torch_idx  = DEF_TORCH;
		enable_idx = DEF_ENABLE;
		ratio_idx  = DEF_RATIO;
		n = q;
		// synchronisers
		n.en_s1  = en_set_pin;
		n.en_s2  = q.en_s1;
		n.en_d   = q.en_s2;
		n.trg_s1 = flash_trigger_in;
		n.trg_s2 = q.trg_s1;
		n.trg_d  = q.trg_s2;
		n.inh_s1 = flash_inhibit_in;
		n.inh_s2 = q.inh_s1;
		n.low_s1 = led_sink_pin_low;
		n.low_s2 = q.low_s1;
		n.ovp_s1 = output_at_ovp;
		n.ovp_s2 = q.ovp_s1;
		n.hot_s1 = over_temp;
		n.hot_s2 = q.hot_s1;
		n.shd_s1 = led_sink_pin_short_ok;
		n.shd_s2 = q.shd_s1;
		// high and low time of the enable pin
		if (q.en_s2) begin
			n.lo_cnt = '0;
			if (q.hi_cnt != LAT_MAX) begin
				n.hi_cnt = q.hi_cnt + 1'b1;
			end
		end else begin
			n.hi_cnt = '0;
			if (q.lo_cnt != OFF_MAX) begin
				n.lo_cnt = q.lo_cnt + 1'b1;
			end
		end
		if (en_rise && q.edges != EDGE_SAT) begin
			n.edges = q.edges + 1'b1;
		end
		// protection delay counters
		if (q.state != ST_SHDN && q.ovp_s2 && q.low_s2) begin
			if (q.flt_cnt != PROT_MAX) begin
				n.flt_cnt = q.flt_cnt + 1'b1;
			end
		end else begin
			n.flt_cnt = '0;
		end
		if (q.state != ST_SHDN && q.hot_s2) begin
			if (q.hot_cnt != PROT_MAX) begin
				n.hot_cnt = q.hot_cnt + 1'b1;
			end
		end else begin
			n.hot_cnt = '0;
		end
		// latched count decode
		if (latch_now) begin
			n.edges = EDGE_NONE;
			if (q.edges >= EDGE_ADDR_MIN && q.edges <= EDGE_ADDR_MAX) begin
				n.addr = 2'(q.edges - EDGE_ADDR_MIN);
			end else if (q.edges <= EDGE_DATA_MAX) begin
				n.reg_val[q.addr] = 4'(q.edges - 1'b1);
				n.reg_set[q.addr] = 1'b1;
			end
		end
		// mode sequencing
		case (q.state)
			ST_SHDN: begin
				n.state = ST_SHDN;
			end
			ST_TEST: begin
				n.test_cnt = q.test_cnt + 1'b1;
				if (q.test_cnt == TST_LAST) begin
					n.chan_dis = !q.shd_s2;
					n.state    = ST_READY;
				end
			end
			ST_READY, ST_DONE: begin
				if (trg_rise) begin
					n.state    = ST_FLASH;
					n.safe_cnt = '0;
					n.quarters = '0;
				end
			end
			ST_FLASH: begin
				if (q.safe_cnt == QTR_LAST) begin
					n.safe_cnt = '0;
					n.quarters = q.quarters + 1'b1;
				end else begin
					n.safe_cnt = q.safe_cnt + 1'b1;
				end
				if (!q.trg_s2 || safe_expire) begin
					n.state = ST_DONE;
				end
			end
			ST_FAULT: begin
				n.state = ST_FAULT;
			end
			default: begin
				n.state = ST_SHDN;
			end
		endcase
		if (fault_now) begin
			n.state = ST_FAULT;
		end
		if (en_rise && !q.enabled) begin
			n.enabled  = 1'b1;
			n.addr     = ADDR_TORCH;
			n.state    = ST_TEST;
			n.test_cnt = '0;
			n.chan_dis = 1'b0;
		end
		if (shut_now) begin
			n.enabled = 1'b0;
			n.state   = ST_SHDN;
			n.addr    = ADDR_TORCH;
			n.reg_val = '0;
			n.reg_set = '0;
			n.edges   = EDGE_NONE;
		end
		// unwritten registers read as defaults
		if (n.reg_set[ADDR_TORCH]) begin
			torch_idx = n.reg_val[ADDR_TORCH];
		end
		if (n.reg_set[ADDR_ENABLE]) begin
			enable_idx = n.reg_val[ADDR_ENABLE];
		end
		if (n.reg_set[ADDR_RATIO]) begin
			ratio_idx = n.reg_val[ADDR_RATIO];
		end
		if (ratio_idx > RATIO_MAX) begin
			ratio_idx = RATIO_MAX;
		end
		// drive outputs
		n.drive = DRV_OFF;
		n.step  = DEF_TORCH;
		n.ratio = 2'(ratio_idx);
		if (!n.chan_dis) begin
			if (n.state == ST_READY && enable_idx >= ENABLE_ON_MIN) begin
				n.drive = DRV_TORCH;
				n.step  = torch_idx;
			end else if (n.state == ST_FLASH && q.inh_s2) begin
				n.drive = DRV_TORCH;
				n.step  = DEF_TORCH;
			end else if (n.state == ST_FLASH) begin
				n.drive = DRV_FLASH;
				n.step  = torch_idx;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			q <= RST_STATE;
		end else begin
			q <= n;
		end
	end

	assign boost_enable     = q.state != ST_SHDN && q.state != ST_FAULT;
	assign test_current_en  = q.state == ST_TEST;
	assign led_drive_mode   = q.drive;
	assign current_step     = q.step;
	assign flash_ratio_sel  = q.ratio;
	assign latched_off      = q.state == ST_FAULT;
	assign channel_disabled = q.chan_dis;

	flash_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.state == ST_READY && trg_rise && !fault_now && !shut_now && q.enabled)
		|=> q.state == ST_FLASH)
		else $error("flash did not start on trigger rise");

	inhibit_torch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.inh_s2 ##1 (q.state == ST_FLASH && !q.chan_dis)
		|-> (led_drive_mode == DRV_TORCH && current_step == DEF_TORCH))
		else $error("inhibit did not reduce flash to default torch");

	no_torch_after_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.state == ST_DONE) |-> led_drive_mode == DRV_OFF)
		else $error("torch resumed after flash");

	fault_latch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.state == ST_FAULT && !shut_now) |=> q.state == ST_FAULT)
		else $error("fault latch released without enable cycle");

	thermal_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.state != ST_SHDN && q.hot_s2 && !shut_now) [*2] ##0 (q.hot_cnt == PROT_MAX)
		|=> latched_off)
		else $error("over-temperature did not latch off");

	flash_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(q.state == ST_FLASH && (!q.trg_s2 || safe_expire)) |=> q.state != ST_FLASH)
		else $error("flash did not end");

	addr_select_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(latch_now && q.edges == EDGE_ADDR_MIN + 5'h02 && !shut_now) |=> q.addr == ADDR_ENABLE)
		else $error("nineteen edges did not select address two");

	data_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(latch_now && q.edges == 5'h05 && !shut_now)
		|=> (q.reg_val[$past(q.addr)] == 4'h4 && q.reg_set[$past(q.addr)]))
		else $error("data count not written to addressed register");

	count_ignore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(latch_now && q.edges > EDGE_ADDR_MAX && !shut_now)
		|=> ($stable(q.addr) && $stable(q.reg_val) && q.edges == EDGE_NONE))
		else $error("oversized count changed state");

	shutdown_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		shut_now |=> (q.reg_set == 4'h0 && q.reg_val == '0 && q.addr == ADDR_TORCH && !boost_enable))
		else $error("shutdown did not clear registers");
endmodule
`default_nettype wire
